// ### lbd_pkg.sv
// shared constants and types for the bridge decode control block
package lbd_pkg;

  // register map (byte addresses, one aligned word each)
  localparam logic [11:0] LBD_GEN_CTRL_ADDR = 12'h000;
  localparam logic [11:0] LBD_STATUS_ADDR   = 12'h004;
  localparam logic [11:0] LBD_PORT60_ADDR   = 12'h008;

  // field positions in bridge_general_control
  localparam int LBD_KBD_LATCH_BIT   = 12;
  localparam int LBD_MOUSE_LATCH_BIT = 11;
  localparam int LBD_ROUTER_EN_BIT   = 8;
  localparam int LBD_EXT_EN_BIT      = 7;
  localparam int LBD_ALT_ACC_BIT     = 6;
  localparam int LBD_DMA_BUF_BIT     = 2;
  localparam int LBD_DEFER_BIT       = 1;
  localparam int LBD_POS_DEC_BIT     = 0;

  // writable bits: 12,11,8,7,6,2,1,0; reserved 10:9 and 5:3 read zero
  localparam logic [31:0] LBD_CTRL_WMASK = 32'h0000_19C7;
  localparam logic [31:0] LBD_CTRL_RESET = 32'h0000_0000;

  // any access to the hidden register outside alternate access is refused with pslverr
  localparam logic [7:0] LBD_PORT60_RESET = 8'h00;

  // decode verdict for one PCI cycle
  typedef struct packed {
    logic claim_pos;     // positively claimed
    logic claim_sub;     // subtractively claimed
    logic hit_router;    // basic router space hit
    logic hit_ext;       // extended router space hit
    logic msg_irq;       // message interrupt write
    logic delayed;       // complete as delayed transaction
  } lbd_decode_s;

  // latched interrupt lines as a pair
  typedef struct packed {
    logic kbd;
    logic mouse;
  } lbd_irq_s;

endpackage

// ### lbd_irq_latch.sv
// edge latch for one legacy interrupt line, cleared by a port 60h read
`timescale 1ns/1ps
module lbd_irq_latch (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic latch_en,
  input  wire logic irq_in,
  input  wire logic port60_rd,
  output logic      irq_out
);
  import lbd_pkg::*;

  typedef struct packed {
    logic prev;
    logic held;
  } lbd_latch_s;

  lbd_latch_s st_r;
  lbd_latch_s st_nxt;

  // a new edge in the clearing cycle wins over the clear
  always_comb begin
    st_nxt      = st_r;
    st_nxt.prev = irq_in;
    if (!latch_en) begin
      st_nxt.held = 1'b0;
    end else if (irq_in && !st_r.prev) begin
      st_nxt.held = 1'b1;
    end else if (port60_rd) begin
      st_nxt.held = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // bypass passes the line straight through when latching is off
  assign irq_out = latch_en ? st_r.held : irq_in;

  // a held edge survives every cycle with latching on and no port 60h read
  hold_until_read_a: assert property (
    @(posedge pclk) disable iff (!presetn)
    latch_en && $past(latch_en) && st_r.held && !port60_rd
      |=> st_r.held)
    else $error("latched interrupt dropped without port 60h read");
endmodule

// ### lbd_decoder.sv
// pci cycle claim decoder steered by the control bits
`timescale 1ns/1ps
module lbd_decoder (
  input  wire logic              router_en,
  input  wire logic              ext_en,
  input  wire logic              pos_only,
  input  wire logic              defer_en,
  input  wire logic              cyc_valid,
  input  wire logic              cyc_write,
  input  wire logic              hit_internal,
  input  wire logic              hit_lpc_known,
  input  wire logic              hit_router_sp,
  input  wire logic              hit_ext_sp,
  input  wire logic              claimed_other,
  output lbd_pkg::lbd_decode_s   verdict
);
  import lbd_pkg::*;

  logic rt;
  logic ex;

  always_comb begin
    rt = router_en && hit_router_sp;
    ex = router_en && ext_en && hit_ext_sp;
    verdict            = '0;
    verdict.hit_router = cyc_valid && rt;
    verdict.hit_ext    = cyc_valid && ex;
    verdict.msg_irq    = cyc_valid && ex && cyc_write;
    verdict.claim_pos  = cyc_valid &&
                         (hit_internal || hit_lpc_known || rt || ex);
    // subtractive claim only for cycles nobody else took
    verdict.claim_sub  = cyc_valid && !pos_only &&
                         !verdict.claim_pos && !claimed_other;
    verdict.delayed    = defer_en && (verdict.claim_pos ||
                                      verdict.claim_sub);
  end
endmodule

// ### lbd_bridge_ctrl.sv
// top: apb control register, irq latches and claim decode for lpc bridge
`timescale 1ns/1ps
module lbd_bridge_ctrl (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  input  wire logic [3:0]        pstrb,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              mouse_interrupt_line,
  input  wire logic              keyboard_interrupt_line,
  input  wire logic              port60_read,
  output lbd_pkg::lbd_irq_s      irq_out,
  input  wire logic              cyc_valid,
  input  wire logic              cyc_write,
  input  wire logic              hit_internal,
  input  wire logic              hit_lpc_known,
  input  wire logic              hit_router_sp,
  input  wire logic              hit_ext_sp,
  input  wire logic              claimed_other,
  output lbd_pkg::lbd_decode_s   verdict,
  output logic                   dma_gather_buffer_enable,
  output logic                   alternate_access_enable
);
  import lbd_pkg::*;

  // all state of the block except the two irq latches
  typedef struct packed {
    logic [31:0] ctrl;
    logic [7:0]  port60;
    logic [31:0] rdata;
    logic        err;
  } lbd_state_s;

  lbd_state_s st_r;
  lbd_state_s st_nxt;

  logic        acc;
  logic        wr;
  logic [31:0] bmask;
  logic [31:0] status_word;
  logic        p60_rd_any;

  // zero wait: every access finishes in its first access cycle
  assign pready = 1'b1;
  assign acc    = psel && penable;
  assign wr     = acc && pwrite;

  // byte lane enables widened to a bit mask
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      bmask[8*i +: 8] = {8{pstrb[i]}};
    end
  end

  // port 60h read from either software mirror or bus side strobe
  assign p60_rd_any = port60_read ||
                      (acc && !pwrite && paddr == LBD_PORT60_ADDR);

  // status shows live latch outputs and decoded mode
  assign status_word = {26'h0,
                        st_r.ctrl[LBD_ROUTER_EN_BIT] &&
                          st_r.ctrl[LBD_EXT_EN_BIT],
                        st_r.ctrl[LBD_ROUTER_EN_BIT],
                        verdict.claim_sub,
                        verdict.claim_pos,
                        irq_out.kbd,
                        irq_out.mouse};

  // register next state; the write mask drops reserved bits
  always_comb begin
    st_nxt     = st_r;
    st_nxt.err = 1'b0;
    if (acc) begin
      st_nxt.rdata = 32'h0;
      case (paddr)
        LBD_GEN_CTRL_ADDR: begin
          if (pwrite) begin
            st_nxt.ctrl = (st_r.ctrl & ~(bmask & LBD_CTRL_WMASK)) |
                          (pwdata & bmask & LBD_CTRL_WMASK);
          end else begin
            st_nxt.rdata = st_r.ctrl & LBD_CTRL_WMASK;
          end
        end
        LBD_STATUS_ADDR: begin
          if (pwrite) begin
            st_nxt.err = 1'b1;   // read-only register
          end else begin
            st_nxt.rdata = status_word;
          end
        end
        LBD_PORT60_ADDR: begin
          // hidden data byte: only reachable in alternate access mode
          if (!st_r.ctrl[LBD_ALT_ACC_BIT]) begin
            st_nxt.err = 1'b1;
          end else if (pwrite) begin
            if (pstrb[0]) begin
              st_nxt.port60 = pwdata[7:0];
            end
          end else begin
            st_nxt.rdata = {24'h0, st_r.port60};
          end
        end
        default: begin
          st_nxt.err = 1'b1;     // unmapped address
        end
      endcase
    end
  end

  // reset clears alternate access and every control bit
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_r.ctrl   <= LBD_CTRL_RESET;
      st_r.port60 <= LBD_PORT60_RESET;
      st_r.rdata  <= 32'h0;
      st_r.err    <= 1'b0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // read data and error are combinational on the access cycle so that
  // zero-wait reads return this cycle's contents
  always_comb begin
    prdata  = 32'h0;
    pslverr = 1'b0;
    if (acc) begin
      prdata  = pwrite ? 32'h0 : st_nxt.rdata;
      pslverr = st_nxt.err;
    end
  end

  // control outputs straight from the register
  assign dma_gather_buffer_enable = st_r.ctrl[LBD_DMA_BUF_BIT];
  assign alternate_access_enable  = st_r.ctrl[LBD_ALT_ACC_BIT];

  // mouse and keyboard edge latches
  lbd_irq_latch u_mouse (
    .pclk      (pclk),
    .presetn   (presetn),
    .latch_en  (st_r.ctrl[LBD_MOUSE_LATCH_BIT]),
    .irq_in    (mouse_interrupt_line),
    .port60_rd (p60_rd_any),
    .irq_out   (irq_out.mouse)
  );

  lbd_irq_latch u_kbd (
    .pclk      (pclk),
    .presetn   (presetn),
    .latch_en  (st_r.ctrl[LBD_KBD_LATCH_BIT]),
    .irq_in    (keyboard_interrupt_line),
    .port60_rd (p60_rd_any),
    .irq_out   (irq_out.kbd)
  );

  // claim decoder; combinational, decides in the cycle it is asked
  lbd_decoder u_dec (
    .router_en     (st_r.ctrl[LBD_ROUTER_EN_BIT]),
    .ext_en        (st_r.ctrl[LBD_EXT_EN_BIT]),
    .pos_only      (st_r.ctrl[LBD_POS_DEC_BIT]),
    .defer_en      (st_r.ctrl[LBD_DEFER_BIT]),
    .cyc_valid     (cyc_valid),
    .cyc_write     (cyc_write),
    .hit_internal  (hit_internal),
    .hit_lpc_known (hit_lpc_known),
    .hit_router_sp (hit_router_sp),
    .hit_ext_sp    (hit_ext_sp),
    .claimed_other (claimed_other),
    .verdict       (verdict)
  );

  // checks: all on pclk, quiet while reset is held
  default clocking lbd_cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  // full word write and plain read of the control register
  sequence s_ctrl_write;
    wr && paddr == LBD_GEN_CTRL_ADDR && (&pstrb);
  endsequence

  sequence s_ctrl_read;
    acc && !pwrite && paddr == LBD_GEN_CTRL_ADDR;
  endsequence

  // reserved bits never leak onto the read bus
  reserved_zero_a: assert property (
    s_ctrl_read |-> (prdata & ~LBD_CTRL_WMASK) == 32'h0)
    else $error("reserved control bits read nonzero");

  // a full word write lands, masked, one cycle after it is taken
  write_takes_a: assert property (
    s_ctrl_write |=>
      st_r.ctrl == ($past(pwdata) & LBD_CTRL_WMASK))
    else $error("control write not taken");

  // router off hides basic and extended space alike
  router_off_a: assert property (
    !st_r.ctrl[LBD_ROUTER_EN_BIT] |->
      !verdict.hit_router && !verdict.hit_ext)
    else $error("router space decoded while disabled");

  // extension bit is ignored while the router is off
  router_msg_off_a: assert property (
    !st_r.ctrl[LBD_ROUTER_EN_BIT] |-> !verdict.msg_irq)
    else $error("message interrupt with router off");

  // basic space only while the extension is off
  ext_off_a: assert property (
    st_r.ctrl[LBD_ROUTER_EN_BIT] && !st_r.ctrl[LBD_EXT_EN_BIT] |->
      !verdict.hit_ext &&
      verdict.hit_router == (cyc_valid && hit_router_sp))
    else $error("extended space decoded with extension off");

  // extended space claimed once router and extension are on
  both_on_a: assert property (
    st_r.ctrl[LBD_ROUTER_EN_BIT] && st_r.ctrl[LBD_EXT_EN_BIT] &&
      cyc_valid && hit_ext_sp |-> verdict.hit_ext && verdict.claim_pos)
    else $error("extended space not decoded");

  // no way to refuse a message write into extended space
  msg_irq_a: assert property (
    verdict.hit_ext && cyc_write |-> verdict.msg_irq)
    else $error("message interrupt write not accepted");

  // positive only mode never claims subtractively
  no_sub_a: assert property (
    st_r.ctrl[LBD_POS_DEC_BIT] |-> !verdict.claim_sub)
    else $error("subtractive claim in positive decode mode");

  // orphan cycles go to lpc when subtractive decode is on
  sub_claim_a: assert property (
    !st_r.ctrl[LBD_POS_DEC_BIT] && cyc_valid && !claimed_other &&
      !hit_internal && !hit_lpc_known && !hit_router_sp && !hit_ext_sp
      |-> verdict.claim_sub)
    else $error("unclaimed cycle not taken subtractively");

  // delayed completion only for claimed cycles with the bit set
  delayed_a: assert property (
    verdict.delayed |-> st_r.ctrl[LBD_DEFER_BIT] &&
      (verdict.claim_pos || verdict.claim_sub))
    else $error("delayed transaction without enable");

  // with the bit clear no cycle is ever delayed
  defer_off_a: assert property (
    !st_r.ctrl[LBD_DEFER_BIT] |-> !verdict.delayed)
    else $error("delayed transaction while disabled");

  // gather buffer enable follows the written bit
  dma_buf_a: assert property (
    s_ctrl_write |=>
      dma_gather_buffer_enable == $past(pwdata[LBD_DMA_BUF_BIT]))
    else $error("gather buffer enable not following write");

  // hidden register is refused outside alternate access
  alt_block_a: assert property (
    acc && paddr == LBD_PORT60_ADDR && !alternate_access_enable
      |-> pslverr)
    else $error("hidden register reached without alternate access");

  // and readable, without error, inside it
  alt_open_a: assert property (
    acc && !pwrite && paddr == LBD_PORT60_ADDR &&
      alternate_access_enable |->
      !pslverr && prdata == {24'h0, st_r.port60})
    else $error("hidden register not readable in alternate access");

  // a rising mouse line is caught by the latch
  mouse_hold_a: assert property (
    st_r.ctrl[LBD_MOUSE_LATCH_BIT] && $rose(mouse_interrupt_line) &&
      $past(st_r.ctrl[LBD_MOUSE_LATCH_BIT]) |=> irq_out.mouse)
    else $error("mouse edge not latched");

  // mouse line passes straight through with latching off
  mouse_pass_a: assert property (
    !st_r.ctrl[LBD_MOUSE_LATCH_BIT] |->
      irq_out.mouse == mouse_interrupt_line)
    else $error("mouse line not bypassed");

  // a rising keyboard line is caught by the latch
  kbd_hold_a: assert property (
    st_r.ctrl[LBD_KBD_LATCH_BIT] && $rose(keyboard_interrupt_line) &&
      $past(st_r.ctrl[LBD_KBD_LATCH_BIT]) |=> irq_out.kbd)
    else $error("keyboard edge not latched");

  // keyboard line passes straight through with latching off
  kbd_pass_a: assert property (
    !st_r.ctrl[LBD_KBD_LATCH_BIT] |->
      irq_out.kbd == keyboard_interrupt_line)
    else $error("keyboard line not bypassed");
endmodule

// ### lbd_pci_model.sv
// pci master model presenting one cycle descriptor per clock
`timescale 1ns/1ps
module lbd_pci_model (
  input  wire logic       pclk,
  input  wire logic       go,
  input  wire logic [5:0] desc,
  output logic            cyc_valid,
  output logic [5:0]      cyc_bits
);
  initial cyc_valid = 1'b0;
  initial cyc_bits = 6'h00;
  // idle bus shows the inverse of the last value so stale data never matches
  always @(posedge pclk) begin
    cyc_valid <= go;
    cyc_bits  <= go ? desc : ~cyc_bits;
  end
endmodule

// ### lbd_bridge_ctrl_tb_top.sv
// self-checking bench for the bridge decode control block
`timescale 1ns/1ps
`define CHK(g, e, m) begin n_checks++; \
  if ((g) !== (e)) begin err_total++; \
  $display("MISMATCH %0t %s", $time, m); end end
module lbd_bridge_ctrl_tb_top;
  import lbd_pkg::*;
  logic        pclk = 1'b0;
  logic        presetn = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic [31:0] ctl;
  logic        pready;
  logic        pslverr;
  logic        err;
  logic        mline = 1'b0;
  logic        kline = 1'b0;
  logic        p60 = 1'b0;
  logic        go = 1'b0;
  logic [5:0]  desc = 6'h00;
  logic [5:0]  cbits;
  logic [5:0]  ev;
  logic        cvalid;
  logic        dmab;
  logic        alt;
  lbd_irq_s    irq;
  lbd_decode_s verdict;
  int          err_total = 0;
  int          n_checks = 0;

  // 40 MHz bench clock
  always #12.5 pclk = ~pclk;

  lbd_pci_model pci (.pclk(pclk), .go(go), .desc(desc),
                     .cyc_valid(cvalid), .cyc_bits(cbits));

  lbd_bridge_ctrl dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .mouse_interrupt_line(mline), .keyboard_interrupt_line(kline),
    .port60_read(p60), .irq_out(irq),
    .cyc_valid(cvalid), .cyc_write(cbits[5]), .hit_internal(cbits[4]),
    .hit_lpc_known(cbits[3]), .hit_router_sp(cbits[2]),
    .hit_ext_sp(cbits[1]), .claimed_other(cbits[0]), .verdict(verdict),
    .dma_gather_buffer_enable(dmab), .alternate_access_enable(alt)
  );

  // reference decode: {claim_pos,claim_sub,hit_router,hit_ext,msg,delayed}
  function automatic logic [5:0] exp_v(logic [31:0] c, logic [5:0] d);
    logic hr;
    logic he;
    logic cp;
    logic cs;
    hr = c[8] & d[2];
    he = c[8] & c[7] & d[1];
    cp = d[4] | d[3] | hr | he;
    cs = !c[0] & !cp & !d[0];
    return {cp, cs, hr, he, he & d[5], c[1] & (cp | cs)};
  endfunction

  task automatic complete_run();
    $display("checks %0d mismatches %0d", n_checks, err_total);
    if (err_total == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // one apb transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_total++;
      complete_run();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // pulse one line; latched copy must outlive the pulse until port 60h read
  task automatic irq_case(input logic kb, input logic en);
    apb(1'b1, LBD_GEN_CTRL_ADDR, en ? (kb ? 32'h1000 : 32'h0800) : 0);
    @(posedge pclk);
    if (kb) kline <= 1'b1;
    else mline <= 1'b1;
    @(negedge pclk);
    `CHK(kb ? irq.kbd : irq.mouse, !en, "raw pass")
    @(posedge pclk);
    mline <= 1'b0;
    kline <= 1'b0;
    @(negedge pclk);
    `CHK(kb ? irq.kbd : irq.mouse, en, "edge held")
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    `CHK(kb ? irq.kbd : irq.mouse, en, "still held")
    @(posedge pclk);
    p60 <= 1'b1;
    @(posedge pclk);
    p60 <= 1'b0;
    @(negedge pclk);
    `CHK(kb ? irq.kbd : irq.mouse, 1'b0, "cleared")
  endtask

  initial begin
    repeat (50000) @(posedge pclk);
    err_total++;
    complete_run();
  end

  initial begin
    void'($urandom(86686));
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    // reset value, reserved bits, hidden register gating
    apb(1'b0, LBD_GEN_CTRL_ADDR, 0);
    `CHK(rd, LBD_CTRL_RESET, "ctrl reset")
    `CHK(alt, 1'b0, "alt reset")
    apb(1'b1, LBD_GEN_CTRL_ADDR, 32'hFFFF_FFFF);
    apb(1'b0, LBD_GEN_CTRL_ADDR, 0);
    `CHK(rd, 32'h0000_19C7, "reserved bits")
    `CHK(dmab, 1'b1, "buffer on")
    `CHK(alt, 1'b1, "alt on")
    apb(1'b1, LBD_PORT60_ADDR, 32'h0000_005A);
    apb(1'b0, LBD_PORT60_ADDR, 0);
    `CHK(rd[7:0], 8'h5A, "hidden readback")
    `CHK(err, 1'b0, "hidden ok")
    apb(1'b1, LBD_GEN_CTRL_ADDR, 0);
    apb(1'b0, LBD_PORT60_ADDR, 0);
    `CHK(err, 1'b1, "hidden refused")
    `CHK(dmab, 1'b0, "buffer off")
    `CHK(alt, 1'b0, "alt off")
    apb(1'b0, 12'h00C, 0);
    `CHK(err, 1'b1, "unmapped")
    apb(1'b1, LBD_STATUS_ADDR, 0);
    `CHK(err, 1'b1, "status read only")
    apb(1'b1, LBD_GEN_CTRL_ADDR, 32'h0000_0180);
    apb(1'b0, LBD_STATUS_ADDR, 0);
    `CHK(rd, 32'h0000_0030, "status modes")
    `CHK(err, 1'b0, "status ok")
    $display("test registers done");
    // every router, extension, positive and deferred combination
    for (int i = 0; i < 16; i++) begin
      ctl = {23'h0, i[0], i[1], 5'h00, i[3], i[2]};
      apb(1'b1, LBD_GEN_CTRL_ADDR, ctl);
      repeat (8) begin
        @(posedge pclk);
        go <= 1'b1;
        desc <= 6'($urandom);
        @(posedge pclk);
        @(negedge pclk);
        ev = exp_v(ctl, cbits);
        `CHK(verdict[5:2], ev[5:2], "claim")
        `CHK(verdict[5:4], ev[5:4], "sub")
        `CHK(verdict[1:0], ev[1:0], "msg dly")
      end
    end
    @(posedge pclk);
    go <= 1'b0;
    $display("test decode done");
    for (int k = 0; k < 4; k++)
      irq_case(k[0], k[1]);
    $display("test latch done");
    complete_run();
  end
endmodule
